// >>> hdl/clkctl_cfg.svh
`ifndef CLKCTL_CFG_SVH
`define CLKCTL_CFG_SVH
// Functional notes
// - protect bit b0 at 1 lets the clock and oscillator registers be written.
// - protect bit b0 at 0 blocks writes to that register group.
// - writing 0 to slow_osc_stop (ctl one b4) runs the slow oscillator.
// - divider field b2..b0, value 000 selects divide-by-2 of fast oscillator.
// - fast_osc_enable (b0) at 1 starts and runs the fast oscillator.
// - fast_osc_select (b1) at 1 makes fast oscillator the on-chip source.
// - after selection, system clock select moves system clock to on-chip.

// ----------------------------------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_PROTECT 8'h00
`define OFS_CTL_ZERO 8'h04
`define OFS_CTL_ONE 8'h08
`define OFS_CTL_THREE 8'h0C
`define OFS_STOP_DET 8'h10
`define OFS_FAST_ZERO 8'h14
`define OFS_FAST_ONE 8'h18
`define OFS_FAST_TWO 8'h1C
`define OFS_FAST_THREE 8'h20
`define OFS_STATUS 8'h24

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BIT_WR_EN 0
`define BIT_SLOW_STOP 4
`define BIT_FAST_EN 0
`define BIT_FAST_SEL 1
`define BIT_SYS_SEL 2
`define RST_PROTECT 8'h00
`define RST_CTL_ONE 8'h10
`define RST_ZERO 8'h00

// ----------------------------------------------------------------
// timing: fast oscillator settle time in ns at 50 ns per cycle
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define FAST_SETTLE_NS 1000
`define FAST_SETTLE_CYC ((`FAST_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> hdl/clkctl_pkg.sv
package clkctl_pkg;
  typedef enum logic [1:0] {
    SRC_SLOW = 2'b00,
    SRC_FAST = 2'b01,
    SRC_SYS = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic slow_run;
    logic fast_run;
    logic fast_ready;
    logic [2:0] fast_div;
    clk_src_t src;
  } clk_state_t;
endpackage

// >>> hdl/osc_settle.sv
`timescale 1ns/100ps
`include "clkctl_cfg.svh"
// counts settle cycles after the fast oscillator is switched on
module osc_settle #(
  parameter int unsigned CYCLES = `FAST_SETTLE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic ready_o
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;

  // refuse a zero count: ready would never rise
  if (CYCLES < 1) begin : g_bad_cycles
    $error("settle count must be at least one");
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // stopping the oscillator drops ready on the next clock edge
  always_comb begin
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    if (!run_i) begin
      cnt_d = '0;
      rdy_d = 1'b0;
    end else if (!rdy_q) begin
      cnt_d = cnt_q + W'(1);
      rdy_d = (cnt_q == W'(CYCLES - 1));
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  assign ready_o = rdy_q;
endmodule

// >>> hdl/clkctl.sv
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "clkctl_cfg.svh"
// clock generation control: protected registers and source selection
module clkctl
  import clkctl_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `FAST_SETTLE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic slow_osc_run_o,
  output logic fast_osc_run_o,
  output logic [2:0] fast_osc_div_o,
  output logic onchip_fast_sel_o,
  output logic sys_clk_onchip_o
);
  // refuse a zero settle count: the source could never leave the slow oscillator
  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("settle count must be at least one");
  end

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] prot_q, prot_d, ctl_zero_q, ctl_zero_d, ctl_one_q, ctl_one_d;
  logic [7:0] ctl_three_q, ctl_three_d, stop_det_q, stop_det_d;
  logic [7:0] fast_zero_q, fast_zero_d, fast_one_q, fast_one_d;
  logic [7:0] fast_two_q, fast_two_d, fast_three_q, fast_three_d;
  logic fast_ready;
  clk_state_t st;

  wire req = (avs_read_i || avs_write_i) && !ack_q;
  wire wr = avs_write_i && ack_q && avs_byteenable_i[0];
  wire unlocked = prot_q[`BIT_WR_EN];
  wire [7:0] wbyte = avs_writedata_i[7:0];

  // write strobe for a protected register at offset ofs
  function automatic logic prot_hit(input logic [7:0] a, input logic [7:0] ofs,
                                    input logic w, input logic en);
    prot_hit = w && en && (a == ofs);
  endfunction

  osc_settle #(
    .CYCLES(SETTLE_CYC)
  ) u_settle (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i(fast_zero_q[`BIT_FAST_EN]),
    .ready_o(fast_ready)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    prot_d = prot_q;
    ctl_zero_d = ctl_zero_q;
    ctl_one_d = ctl_one_q;
    ctl_three_d = ctl_three_q;
    stop_det_d = stop_det_q;
    fast_zero_d = fast_zero_q;
    fast_one_d = fast_one_q;
    fast_two_d = fast_two_q;
    fast_three_d = fast_three_q;
    if (wr && avs_address_i == `OFS_PROTECT) prot_d = wbyte;
    if (prot_hit(avs_address_i, `OFS_CTL_ZERO, wr, unlocked)) ctl_zero_d = wbyte;
    if (prot_hit(avs_address_i, `OFS_CTL_ONE, wr, unlocked)) ctl_one_d = wbyte;
    if (prot_hit(avs_address_i, `OFS_CTL_THREE, wr, unlocked)) ctl_three_d = wbyte;
    if (prot_hit(avs_address_i, `OFS_STOP_DET, wr, unlocked)) stop_det_d = wbyte;
    if (prot_hit(avs_address_i, `OFS_FAST_ZERO, wr, unlocked)) fast_zero_d = wbyte;
    if (prot_hit(avs_address_i, `OFS_FAST_ONE, wr, unlocked)) fast_one_d = wbyte;
    if (prot_hit(avs_address_i, `OFS_FAST_TWO, wr, unlocked)) fast_two_d = {5'h00, wbyte[2:0]};
    if (prot_hit(avs_address_i, `OFS_FAST_THREE, wr, unlocked)) fast_three_d = wbyte;
  end

  // read mux and wait state; unmapped offsets read zero
  // waitrequest has its own flop so the pin never sees an inverter glitch
  always_comb begin
    ack_d = req;
    wait_d = !req;
    rdata_d = 32'h0000_0000;
    unique case (avs_address_i)
      `OFS_PROTECT: rdata_d[7:0] = prot_q;
      `OFS_CTL_ZERO: rdata_d[7:0] = ctl_zero_q;
      `OFS_CTL_ONE: rdata_d[7:0] = ctl_one_q;
      `OFS_CTL_THREE: rdata_d[7:0] = ctl_three_q;
      `OFS_STOP_DET: rdata_d[7:0] = stop_det_q;
      `OFS_FAST_ZERO: rdata_d[7:0] = fast_zero_q;
      `OFS_FAST_ONE: rdata_d[7:0] = fast_one_q;
      `OFS_FAST_TWO: rdata_d[7:0] = fast_two_q;
      `OFS_FAST_THREE: rdata_d[7:0] = fast_three_q;
      `OFS_STATUS: rdata_d[7:0] = {6'h00, st.src};
      default: rdata_d = 32'h0000_0000;
    endcase
    rdata_d[8] = (avs_address_i == `OFS_STATUS) ? fast_ready : rdata_d[8];
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      prot_q <= `RST_PROTECT;
      ctl_zero_q <= `RST_ZERO;
      ctl_one_q <= `RST_CTL_ONE;
      ctl_three_q <= `RST_ZERO;
      stop_det_q <= `RST_ZERO;
      fast_zero_q <= `RST_ZERO;
      fast_one_q <= `RST_ZERO;
      fast_two_q <= `RST_ZERO;
      fast_three_q <= `RST_ZERO;
    end else begin
      ack_q <= ack_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      prot_q <= prot_d;
      ctl_zero_q <= ctl_zero_d;
      ctl_one_q <= ctl_one_d;
      ctl_three_q <= ctl_three_d;
      stop_det_q <= stop_det_d;
      fast_zero_q <= fast_zero_d;
      fast_one_q <= fast_one_d;
      fast_two_q <= fast_two_d;
      fast_three_q <= fast_three_d;
    end
  end

  // ----------------------------------------------------------------
  // clock control outputs
  // ----------------------------------------------------------------
  clk_state_t out_q, out_d;
  logic sel_q, sel_d, sys_q, sys_d;
  assign st = out_q;

  // source only moves to the fast oscillator once it has settled, so an
  // early select from software cannot glitch the system clock
  always_comb begin
    out_d.fast_ready = fast_ready;
    // stop bit low runs slow oscillator
    out_d.slow_run = !ctl_one_q[`BIT_SLOW_STOP];
    out_d.fast_run = fast_zero_q[`BIT_FAST_EN];
    out_d.fast_div = fast_two_q[2:0];
    if (fast_zero_q[`BIT_FAST_SEL] && fast_zero_q[`BIT_FAST_EN] && fast_ready) begin
      out_d.src = stop_det_q[`BIT_SYS_SEL] ? SRC_SYS : SRC_FAST;
    end else begin
      out_d.src = SRC_SLOW;
    end
    // decoded select flags get flops of their own, so the pins stay clean
    sel_d = out_d.src != SRC_SLOW;
    sys_d = out_d.src == SRC_SYS;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= '0;
      sel_q <= 1'b0;
      sys_q <= 1'b0;
    end else begin
      out_q <= out_d;
      sel_q <= sel_d;
      sys_q <= sys_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;
  assign slow_osc_run_o = out_q.slow_run;
  assign fast_osc_run_o = out_q.fast_run;
  assign fast_osc_div_o = out_q.fast_div;
  assign onchip_fast_sel_o = sel_q;
  assign sys_clk_onchip_o = sys_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  locked_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!unlocked && wr && avs_address_i == `OFS_FAST_ZERO) |=> $stable(fast_zero_q))
    else $error("locked write changed fast control");
  open_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (unlocked && wr && avs_address_i == `OFS_CTL_ONE) |=> ctl_one_q == $past(wbyte))
    else $error("unlocked write not stored");
  lock_blocks_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !unlocked |=> $stable(ctl_one_q) && $stable(stop_det_q) && $stable(fast_two_q))
    else $error("protected register changed while locked");
  slow_run_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 slow_osc_run_o == !$past(ctl_one_q[`BIT_SLOW_STOP]))
    else $error("slow oscillator run mismatch");
  div_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fast_two_q == 8'h00) |=> fast_osc_div_o == 3'b000)
    else $error("divider output mismatch");
  div_follow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 fast_osc_div_o == $past(fast_two_q[2:0]))
    else $error("divider output does not follow field");
  fast_run_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(fast_zero_q[`BIT_FAST_EN]) |-> !fast_osc_run_o ##1 fast_osc_run_o)
    else $error("fast oscillator did not start");
  fast_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    onchip_fast_sel_o |-> fast_osc_run_o)
    else $error("fast source selected while stopped");
  settle_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(onchip_fast_sel_o) |-> $past(fast_ready))
    else $error("fast source taken before settle");
  sys_clk_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    sys_clk_onchip_o |-> onchip_fast_sel_o && $past(stop_det_q[`BIT_SYS_SEL]))
    else $error("system clock moved without selection");
  bus_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus answer late");
  // waitrequest low stands one cycle only, so a held request is not taken twice
  wait_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  cover_unlock_c: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(unlocked));
  cover_fast_c: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(onchip_fast_sel_o));
  cover_sys_c: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(sys_clk_onchip_o));
  cover_locked_c: cover property (@(posedge mclk_i) disable iff (rst_i) !unlocked && wr);
endmodule

// >>> tb/onchip_oscillator_clock_setup_test.sv
`timescale 1ns/100ps
`include "clkctl_cfg.svh"
module onchip_oscillator_clock_setup_test
  import clkctl_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [3:0] lanes = 4'h1;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic slow_osc_run_o;
  logic fast_osc_run_o;
  logic [2:0] fast_osc_div_o;
  logic onchip_fast_sel_o;
  logic sys_clk_onchip_o;
  int err_total = 0;
  int comparisons = 0;

  // short settle count keeps the run brief
  clkctl #(.SETTLE_CYC(2)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .slow_osc_run_o(slow_osc_run_o), .fast_osc_run_o(fast_osc_run_o),
    .fast_osc_div_o(fast_osc_div_o), .onchip_fast_sel_o(onchip_fast_sel_o),
    .sys_clk_onchip_o(sys_clk_onchip_o)
  );

  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // reporting and comparison
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // outputs are packed as {fast_sel, sys_onchip, slow_run, fast_run, div}
  task automatic chk_out(input logic [6:0] exp);
    logic [6:0] got;
    got = {onchip_fast_sel_o, sys_clk_onchip_o, slow_osc_run_o, fast_osc_run_o, fast_osc_div_o};
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // avalon master: hold request until waitrequest is seen low
  // ----------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h00_0000, d};
    avs_byteenable_i <= lanes;
    // waitrequest is taken as it stands at each rising edge
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      err_total++;
      finish_test();
    end
    // the write lands and read data is taken at this same edge
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk_reg(q, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_state();
    rdchk(`OFS_PROTECT, 32'h0000_0000);
    rdchk(`OFS_CTL_ONE, 32'h0000_0010);
    rdchk(`OFS_FAST_ZERO, 32'h0000_0000);
    chk_out(7'h00);
  endtask

  // writes while protected are dropped
  task automatic locked_writes();
    wr(`OFS_CTL_ONE, 8'h00);
    wr(`OFS_FAST_TWO, 8'h05);
    wr(`OFS_FAST_ZERO, 8'h03);
    wr(`OFS_STOP_DET, 8'h04);
    rdchk(`OFS_CTL_ONE, 32'h0000_0010);
    rdchk(`OFS_FAST_TWO, 32'h0000_0000);
    chk_out(7'h00);
  endtask

  // unlock, then run the slow oscillator
  task automatic unlock_slow();
    wr(`OFS_PROTECT, 8'h01);
    rdchk(`OFS_PROTECT, 32'h0000_0001);
    // a write with byte lane 0 off must not land
    lanes = 4'h0;
    wr(`OFS_CTL_ONE, 8'h00);
    lanes = 4'h1;
    rdchk(`OFS_CTL_ONE, 32'h0000_0010);
    wr(`OFS_CTL_ONE, 8'h00);
    rdchk(`OFS_CTL_ONE, 32'h0000_0000);
    chk_out(7'h10);
  endtask

  // every divider code, then a wide value trimmed to three bits
  task automatic divider_codes();
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_FAST_TWO, 8'(i));
      rdchk(`OFS_FAST_TWO, 32'(i));
      chk_out({4'h2, 3'(i)});
    end
    wr(`OFS_FAST_TWO, 8'hFF);
    rdchk(`OFS_FAST_TWO, 32'h0000_0007);
    wr(`OFS_FAST_TWO, 8'h00);
    rdchk(`OFS_FAST_TWO, 32'h0000_0000);
    chk_out(7'h10);
  endtask

  // enable, wait for ready, select, then move the system clock
  task automatic fast_switch();
    logic [31:0] q;
    int n;
    wr(`OFS_FAST_ZERO, 8'h01);
    rdchk(`OFS_FAST_ZERO, 32'h0000_0001);
    chk_out(7'h18);
    n = 0;
    do begin
      bus(`OFS_STATUS, 1'b0, 8'h00, q);
      n++;
    end while (q[8] !== 1'b1 && n < 20);
    if (q[8] !== 1'b1) begin
      err_total++;
      finish_test();
    end
    chk_reg(q, 32'h0000_0100);
    wr(`OFS_FAST_ZERO, 8'h03);
    rdchk(`OFS_STATUS, 32'h0000_0101);
    chk_out(7'h58);
    wr(`OFS_STOP_DET, 8'h04);
    rdchk(`OFS_STATUS, 32'h0000_0103);
    chk_out(7'h78);
  endtask

  // relock, then two dropped writes and an unmapped place
  task automatic relock_unmapped();
    wr(`OFS_PROTECT, 8'h00);
    wr(`OFS_FAST_ZERO, 8'h00);
    wr(`OFS_FAST_TWO, 8'h06);
    rdchk(`OFS_FAST_ZERO, 32'h0000_0003);
    rdchk(`OFS_FAST_TWO, 32'h0000_0000);
    chk_out(7'h78);
    wr(8'h40, 8'hAA);
    rdchk(8'h40, 32'h0000_0000);
  endtask

  // reset in mid-run returns the outputs, waitrequest and the protect, ctl one and fast zero registers to idle
  task automatic mid_reset();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk_out(7'h00);
    chk_reg(32'(avs_waitrequest_o), 32'h0000_0001);
    rst_i <= 1'b0;
    reset_state();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    reset_state();
    locked_writes();
    unlock_slow();
    divider_codes();
    fast_switch();
    relock_unmapped();
    mid_reset();
    finish_test();
  end
endmodule
